// ===== logic/ir_endec_pkg.sv
// constants and carrier types for the infrared pulse encoder/decoder
// assumes a uart on the same clock supplies its serial line and settings
// Behaviour
// - each bit spans sixteen baud clocks
// - one bit keeps transmit output low
// - zero bit: low 7, high 3, low 6
// - encoder enabled: pin carries pulses, not uart
// - decoder enabled: uart receive fed from decoder
// - half duplex, no receive while a zero bit is transmitted
// - bit rate is clock over 16 times divisor
// - infrared traffic only while uart enabled
// - decoder counter runs zero to fifteen
// - decoded stream lags input by eight clocks
// - falling edge resets decoder counter
// - count eight updates uart receive value
// - count twelve opens pulse window
// - window closes when count reaches eight
// - pulse repeats cycle, none decodes one
// - decoder never alters uart own timing
// - no register set of its own
// - baud divisor is sixteen bits wide
package ir_endec_pkg;

    // ==========================================================
    // bit timing in baud clocks
    localparam int unsigned BIT_CLKS       = 16;
    localparam logic [3:0]  BIT_LAST       = 4'hF;
    localparam logic [3:0]  TX_PULSE_START = 4'h7;
    localparam logic [3:0]  TX_PULSE_END   = 4'hA;
    localparam logic [3:0]  DEC_UPDATE_PRE = 4'h7;
    localparam logic [3:0]  DEC_UPDATE_CNT = 4'h8;
    localparam logic [3:0]  DEC_WIN_OPEN   = 4'hC;
    localparam logic [3:0]  CNT_RESET      = 4'h0;

    // ==========================================================
    // system clock and shortest incoming pulse
    localparam int unsigned SYS_CLK_HZ       = 40_000_000;
    localparam int unsigned MIN_PULSE_NS     = 1400;
    localparam int unsigned MIN_PULSE_CYCLES =
        (MIN_PULSE_NS * (SYS_CLK_HZ / 1_000_000)) / 1000;

    // ==========================================================
    // reset values
    localparam logic [15:0] DIV_CNT_RST = 16'h0000;
    localparam logic        TX_PIN_RST  = 1'b0;
    localparam logic        RX_LINE_RST = 1'b1;

    typedef enum logic [0:0] {
        DEC_IDLE  = 1'b0,
        DEC_TRACK = 1'b1
    } dec_state_t;

    // settings held in the uart control registers
    typedef struct packed {
        logic        uart_enable;
        logic        infrared_enable_bit;
        logic [15:0] baud_divisor;
    } endec_cfg_t;

endpackage

// ===== logic/infrared_pulse_endec.sv
// infrared pulse encoder/decoder between a uart and an infrared transceiver
// assumes cfg and uart_txd_in come from the uart on sys_clk_in;
// rxd_pin_in is asynchronous and is synchronised here
`timescale 1ns/10ps
`default_nettype none

module infrared_pulse_endec (
    // clock and reset
    input  wire logic                    sys_clk_in,
    input  wire logic                    nrst_in,
    // uart control settings
    input  wire ir_endec_pkg::endec_cfg_t cfg_in,
    // uart serial lines
    input  wire logic                    uart_txd_in,
    output logic                         uart_rxd_out,
    // device pins
    input  wire logic                    rxd_pin_in,
    output logic                         txd_pin_out,
    // status
    output logic                         baud_tick_out
);
    import ir_endec_pkg::*;

    // ==========================================================
    // mode decode
    wire ir_on;
    wire ir_off;
    assign ir_on  = cfg_in.infrared_enable_bit & cfg_in.uart_enable;
    assign ir_off = ~cfg_in.infrared_enable_bit;

    // ==========================================================
    // 16x baud tick from the 16-bit divisor
    logic [15:0] div_cnt_q;
    logic [15:0] div_cnt_d;
    logic        tick_q;
    wire  [15:0] div_last;
    wire         div_wrap;

    assign div_last  = (cfg_in.baud_divisor == 16'h0000) ? 16'h0000
                     : cfg_in.baud_divisor - 16'h0001;
    assign div_wrap  = (div_cnt_q >= div_last);
    assign div_cnt_d = div_wrap ? DIV_CNT_RST : div_cnt_q + 16'h0001;

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            div_cnt_q <= DIV_CNT_RST;
            tick_q    <= 1'b0;
        end else begin
            div_cnt_q <= cfg_in.uart_enable ? div_cnt_d : DIV_CNT_RST;
            tick_q    <= cfg_in.uart_enable & div_wrap;
        end
    end

    // ==========================================================
    // encoder: bit phase restarts on every uart line change
    logic       txd_prev_q;
    logic       tx_bit_q;
    logic [3:0] tx_cnt_q;
    logic [3:0] tx_cnt_d;
    wire        tx_edge;
    wire        tx_pulse;

    assign tx_edge  = (uart_txd_in != txd_prev_q);
    assign tx_cnt_d = tx_edge ? CNT_RESET
                    : (tick_q ? tx_cnt_q + 4'h1 : tx_cnt_q);
    assign tx_pulse = ~tx_bit_q & (tx_cnt_q >= TX_PULSE_START)
                    & (tx_cnt_q < TX_PULSE_END);

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            txd_prev_q <= 1'b1;
            tx_bit_q   <= 1'b1;
            tx_cnt_q   <= CNT_RESET;
        end else begin
            txd_prev_q <= uart_txd_in;
            tx_cnt_q   <= tx_cnt_d;
            if (tx_edge) begin
                tx_bit_q <= uart_txd_in;
            end
        end
    end

    // ==========================================================
    // receive pin synchroniser and edge detect
    logic rx_s1_q;
    logic rx_s2_q;
    logic rx_s3_q;
    wire  rx_fall;
    wire  tx_busy;

    assign tx_busy = ir_on & ~tx_bit_q;
    assign rx_fall = rx_s3_q & ~rx_s2_q & ~tx_busy;

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            rx_s1_q <= RX_LINE_RST;
            rx_s2_q <= RX_LINE_RST;
            rx_s3_q <= RX_LINE_RST;
        end else begin
            rx_s1_q <= rxd_pin_in;
            rx_s2_q <= rx_s1_q;
            rx_s3_q <= rx_s2_q;
        end
    end

    // ==========================================================
    // decoder
    dec_state_t dec_state_q;
    dec_state_t dec_state_d;
    logic [3:0] dec_cnt_q;
    logic [3:0] dec_cnt_d;
    logic       got_q;
    logic       got_d;
    logic       dec_out_q;
    logic       dec_out_d;
    wire        win_open;
    wire        hit;
    wire        at_update;

    // window spans counts 12..15 and 0..7, once per bit
    assign win_open  = ~got_q & ((dec_cnt_q >= DEC_WIN_OPEN)
                     | (dec_cnt_q < DEC_UPDATE_CNT));
    assign hit       = rx_fall & ((dec_state_q == DEC_IDLE) | win_open);
    assign at_update = tick_q & (dec_cnt_q == DEC_UPDATE_PRE);

    always_comb begin
        dec_state_d = dec_state_q;
        dec_cnt_d   = dec_cnt_q;
        got_d       = got_q;
        dec_out_d   = dec_out_q;
        case (dec_state_q)
            DEC_IDLE: begin
                dec_out_d = 1'b1;
                if (hit) begin
                    dec_state_d = DEC_TRACK;
                    dec_cnt_d   = CNT_RESET;
                    got_d       = 1'b1;
                end
            end
            DEC_TRACK: begin
                if (hit) begin
                    dec_cnt_d = CNT_RESET;
                    got_d     = 1'b1;
                end else if (at_update) begin
                    dec_cnt_d = DEC_UPDATE_CNT;
                    dec_out_d = ~got_q;
                    got_d     = 1'b0;
                    if (!got_q) begin
                        dec_state_d = DEC_IDLE;
                    end
                end else if (tick_q) begin
                    dec_cnt_d = dec_cnt_q + 4'h1;
                end
            end
            default: begin
                dec_state_d = DEC_IDLE;
                dec_out_d   = 1'b1;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in || !ir_on) begin
            dec_state_q <= DEC_IDLE;
            dec_cnt_q   <= CNT_RESET;
            got_q       <= 1'b0;
            dec_out_q   <= RX_LINE_RST;
        end else begin
            dec_state_q <= dec_state_d;
            dec_cnt_q   <= dec_cnt_d;
            got_q       <= got_d;
            dec_out_q   <= dec_out_d;
        end
    end

    // ==========================================================
    // pin and uart line selection, registered before the outputs
    wire txd_sel;
    wire rxd_sel;

    assign txd_sel = ir_off ? uart_txd_in
                   : (ir_on & tx_pulse);
    assign rxd_sel = ir_off ? rx_s2_q
                   : (ir_on ? dec_out_q : RX_LINE_RST);

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            txd_pin_out   <= TX_PIN_RST;
            uart_rxd_out  <= RX_LINE_RST;
            baud_tick_out <= 1'b0;
        end else begin
            txd_pin_out   <= txd_sel;
            uart_rxd_out  <= rxd_sel;
            baud_tick_out <= tick_q;
        end
    end

    // ==========================================================
    // checks
    a_tx_one_low: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        ($past(ir_on) && $past(tx_bit_q)) |-> !txd_pin_out)
        else $error("transmit pin high while sending a one");

    a_tx_pulse_rise: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        ($rose(txd_pin_out) && $past(ir_on) && $past(ir_on, 2))
        |-> ($past(tx_cnt_q) == 4'h7))
        else $error("infrared pulse did not start at count 7");

    a_tx_pulse_fall: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        ($fell(txd_pin_out) && $past(ir_on) && $past(ir_on, 2) && !$past(tx_edge, 2))
        |-> ($past(tx_cnt_q) == 4'hA))
        else $error("infrared pulse did not end at count 10");

    a_tx_pin_source: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        ($past(ir_on) && $past(nrst_in)) |-> (txd_pin_out == $past(tx_pulse)))
        else $error("transmit pin not driven by encoder");

    a_rx_from_dec: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        ($past(ir_on) && $past(nrst_in)) |-> (uart_rxd_out == $past(dec_out_q)))
        else $error("uart receive not taken from decoder");

    a_bypass_path: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        ($past(ir_off) && $past(nrst_in)) |-> (txd_pin_out == $past(uart_txd_in)
                           && uart_rxd_out == $past(rx_s2_q)))
        else $error("bypass path broken");

    a_uart_off_quiet: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        (cfg_in.infrared_enable_bit && !cfg_in.uart_enable)
        |=> (!txd_pin_out && uart_rxd_out))
        else $error("infrared traffic with uart disabled");

    a_half_duplex: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        tx_busy |-> !hit)
        else $error("receive edge accepted while transmitting");

    a_edge_resets: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        (hit && ir_on) |=> (dec_cnt_q == 4'h0 && got_q))
        else $error("falling edge did not reset counter");

    a_update_at_8: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        (ir_on && dec_state_q == DEC_TRACK && at_update && !hit)
        |=> (dec_cnt_q == 4'h8 && dec_out_q == !$past(got_q)))
        else $error("decoder output not updated at count 8");

    a_no_pulse_idle: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        (ir_on && dec_state_q == DEC_TRACK && at_update && !got_q && !hit)
        |=> (dec_state_q == DEC_IDLE) ##1 uart_rxd_out)
        else $error("missing pulse not decoded as one");

    a_window_closed: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        (dec_state_q == DEC_TRACK && dec_cnt_q >= 4'h8 && dec_cnt_q < 4'hC)
        |-> !win_open)
        else $error("window open between counts 8 and 11");

    a_idle_high: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        (dec_state_q == DEC_IDLE && $past(dec_state_q) == DEC_IDLE) |-> dec_out_q)
        else $error("decoder output low while idle");

    a_tick_off: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        !cfg_in.uart_enable |=> !tick_q)
        else $error("baud tick while uart disabled");

    a_dec_held_off: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        !ir_on |=> (dec_state_q == DEC_IDLE && dec_out_q))
        else $error("decoder active while infrared path off");

    a_tick_at_wrap: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        (cfg_in.uart_enable && div_wrap) |=> (tick_q && div_cnt_q == DIV_CNT_RST))
        else $error("baud tick missing at divisor wrap");

    a_tx_phase_restart: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        tx_edge |=> (tx_cnt_q == CNT_RESET && tx_bit_q == $past(uart_txd_in)))
        else $error("encoder phase not restarted on bit edge");

    a_dec_count_step: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        (ir_on && dec_state_q == DEC_TRACK && tick_q && !hit && !at_update)
        |=> (dec_cnt_q == $past(dec_cnt_q) + 4'h1))
        else $error("decoder counter did not step on tick");

    a_one_pulse_window: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        (dec_state_q == DEC_TRACK && got_q) |-> !win_open)
        else $error("second pulse accepted in one window");

    a_out_on_update: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        ($changed(dec_out_q) && $past(ir_on) && $past(nrst_in)) |-> $past(at_update))
        else $error("decoder output changed between updates");

    c_tx_pulse: cover property (@(posedge sys_clk_in) disable iff (!nrst_in)
        ir_on && $rose(txd_pin_out));

    c_dec_zero: cover property (@(posedge sys_clk_in) disable iff (!nrst_in)
        ir_on && $fell(uart_rxd_out));

    c_win_rehit: cover property (@(posedge sys_clk_in) disable iff (!nrst_in)
        dec_state_q == DEC_TRACK && hit && dec_cnt_q >= 4'hC);

    c_bypass: cover property (@(posedge sys_clk_in) disable iff (!nrst_in)
        ir_off && $fell(txd_pin_out));

    c_dec_idle_return: cover property (@(posedge sys_clk_in) disable iff (!nrst_in)
        ir_on && dec_state_q == DEC_TRACK ##1 dec_state_q == DEC_IDLE);

endmodule

`default_nettype wire

// ===== test/ir_xcvr_model.sv
// behavioural infrared transceiver that drives the receive pin
// assumes tick_in is the block's own baud tick, one cycle wide
`timescale 1ns/10ps
`default_nettype none

module ir_xcvr_model (
    // clock and baud tick
    input  wire logic sys_clk_in,
    input  wire logic tick_in,
    // receive pin, idles high
    output logic      rx_pin_out
);
    initial rx_pin_out = 1'b1;

    // ==========================================================
    // slot timing
    task automatic wait_ticks(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk_in iff tick_in);
        end
    endtask

    // one 16 tick slot; a zero carries a 3 tick low pulse, j shifts it
    task automatic send_slot(input logic b, input int j);
        wait_ticks(7 + j);
        @(negedge sys_clk_in);
        rx_pin_out = b;
        wait_ticks(3);
        @(negedge sys_clk_in);
        rx_pin_out = 1'b1;
        wait_ticks(6 - j);
    endtask
endmodule

`default_nettype wire

// ===== test/infrared_pulse_endec_test.sv
// self-checking bench for the infrared pulse encoder/decoder
// assumes the bench plays the uart and ir_xcvr_model drives the pin
`timescale 1ns/10ps
`default_nettype none

module infrared_pulse_endec_test;
    import ir_endec_pkg::*;

    localparam logic [15:0] DIV = 16'h0014;

    logic       sys_clk_in;
    logic       nrst_in;
    endec_cfg_t cfg_in;
    logic       uart_txd_in;
    logic       pin_low;
    logic       model_pin;
    logic       uart_rxd_out;
    logic       txd_pin_out;
    logic       baud_tick_out;
    wire logic  rxd_pin_in = model_pin & ~pin_low;
    int         num_errors;
    int         cmp_count;
    int         cycles;

    infrared_pulse_endec u_dut (
        .sys_clk_in    (sys_clk_in),
        .nrst_in       (nrst_in),
        .cfg_in        (cfg_in),
        .uart_txd_in   (uart_txd_in),
        .uart_rxd_out  (uart_rxd_out),
        .rxd_pin_in    (rxd_pin_in),
        .txd_pin_out   (txd_pin_out),
        .baud_tick_out (baud_tick_out)
    );

    ir_xcvr_model xcvr (
        .sys_clk_in (sys_clk_in),
        .tick_in    (baud_tick_out),
        .rx_pin_out (model_pin)
    );

    // ==========================================================
    // clock, timeout and helpers
    initial begin
        sys_clk_in = 1'b0;
        forever #12.5 sys_clk_in = ~sys_clk_in;
    end

    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            give_verdict();
        end
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %0h, seen %0h", name, exp, seen);
        end
    endtask

    task automatic give_verdict();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk_in);
    endtask

    task automatic set_cfg(input logic en, input logic ir, input logic [15:0] d);
        cyc(1);
        cfg_in = '{uart_enable: en, infrared_enable_bit: ir, baud_divisor: d};
    endtask

    // ==========================================================
    // scenarios
    task automatic test_bypass();
        set_cfg(1'b1, 1'b0, DIV);
        uart_txd_in = 1'b0;
        cyc(3);
        check("tx_bypass_lo", txd_pin_out, 1'b0);
        uart_txd_in = 1'b1;
        cyc(3);
        check("tx_bypass_hi", txd_pin_out, 1'b1);
        pin_low = 1'b1;
        cyc(5);
        check("rx_bypass_lo", uart_rxd_out, 1'b0);
        pin_low = 1'b0;
        cyc(5);
        check("rx_bypass_hi", uart_rxd_out, 1'b1);
    endtask

    // disabled uart stays silent, then the tick period equals the divisor
    task automatic test_baud(input logic [15:0] d);
        int   n;
        logic seen;
        set_cfg(1'b0, 1'b1, d);
        uart_txd_in = 1'b0;
        pin_low = 1'b1;
        seen = 1'b0;
        for (n = 0; n < 64; n++) begin
            cyc(1);
            seen = seen | baud_tick_out | txd_pin_out | ~uart_rxd_out;
        end
        check("off_activity", seen, 1'b0);
        pin_low = 1'b0;
        uart_txd_in = 1'b1;
        cyc(4);
        set_cfg(1'b1, 1'b1, d);
        @(negedge sys_clk_in iff baud_tick_out);
        n = 0;
        do begin
            cyc(1);
            n++;
        end while (baud_tick_out !== 1'b1 && n < 100);
        check("tick_period", n[15:0], d);
    endtask

    task automatic test_encode(input logic b);
        int hi;
        int lo;
        hi = 0;
        lo = 0;
        uart_txd_in = b;
        repeat (16 * DIV) begin
            cyc(1);
            hi += txd_pin_out;
            if (hi == 0) lo++;
        end
        check("pulse_len", hi[15:0], b ? 16'h0000 : 3 * DIV);
        if (b == 1'b0) begin
            check("pulse_gap", (lo >= 6 * DIV && lo <= 8 * DIV), 1'b1);
        end
    endtask

    // jittered pulses, a lone one bit and a return to idle
    task automatic test_decode();
        logic [6:0] bits;
        int         jit [7] = '{0, 0, 2, 0, -3, 0, 0};
        bits = 7'h62;
        check("rx_idle", uart_rxd_out, 1'b1);
        for (int i = 0; i < 7; i++) begin
            fork
                xcvr.send_slot(bits[i], jit[i]);
                begin
                    xcvr.wait_ticks(3);
                    cyc(1);
                    if (i > 0) begin
                        check("rx_bit", uart_rxd_out, bits[i - 1]);
                    end
                end
            join
        end
    endtask

    task automatic test_duplex();
        cyc(1);
        uart_txd_in = 1'b0;
        xcvr.send_slot(1'b0, 0);
        xcvr.wait_ticks(4);
        cyc(1);
        check("rx_duplex", uart_rxd_out, 1'b1);
        uart_txd_in = 1'b1;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        nrst_in = 1'b0;
        cfg_in = '0;
        uart_txd_in = 1'b1;
        pin_low = 1'b0;
        num_errors = 0;
        cmp_count = 0;
        cyc(8);
        check("tx_reset", txd_pin_out, TX_PIN_RST);
        check("rx_reset", uart_rxd_out, RX_LINE_RST);
        nrst_in = 1'b1;
        test_bypass();
        test_baud(16'h0007);
        test_baud(DIV);
        test_encode(1'b0);
        test_encode(1'b0);
        test_encode(1'b1);
        test_encode(1'b0);
        test_encode(1'b1);
        test_decode();
        test_duplex();
        give_verdict();
    end
endmodule

`default_nettype wire
